/* rtl/sac_port.sv */
// Our own choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
module sac_port
  import sac_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // apb slave
  input wire logic [7:0] paddr_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // serial link
  input wire sac_link_in_type link_in,
  output logic result_data_out,
  output logic result_oe_out,
  output logic conv_done_out,
  // analog core
  input wire logic [RES_W-1:0] analog_level_in,
  input wire logic above_ref_in,
  input wire logic below_ref_in,
  output logic [ADDR_W-1:0] analog_channels_sel_out,
  output logic sample_active_out,
  // interrupt
  output logic irq_out
);
  typedef enum logic [1:0] {L_OFF, L_SETUP, L_SHIFT, L_HOLD} sac_lst_type;
  typedef enum logic {C_IDLE, C_CONV} sac_cst_type;

  function automatic logic [CNT_W-1:0] len_of(input logic [1:0] code);
    if (code == LEN_CODE_8) return LEN_8;
    if (code == LEN_CODE_16) return LEN_16;
    return LEN_12;
  endfunction : len_of

  // result aligned to the top of the output shifter
  function automatic logic [OUT_W-1:0] fmt_word(input sac_result_type r,
                                                input sac_fmt_type f);
    logic [RES_W-1:0] c;
    c = r.code;
    if (f.bipolar) c[RES_W-1] = ~c[RES_W-1];
    if (f.lsb_first) c = {<<{c}};
    return {c, {(OUT_W-RES_W){1'b0}}};
  endfunction : fmt_word

  function automatic logic [RES_W-1:0] conv_code(input logic [ADDR_W-1:0] a,
                                                 input logic [RES_W-1:0] lv,
                                                 input logic hi,
                                                 input logic lo);
    if (a == ADDR_TEST_MID) return CODE_MID;
    if (a == ADDR_TEST_ZERO) return CODE_ZERO;
    if (a == ADDR_TEST_FULL) return CODE_FULL;
    if (hi) return CODE_FULL;
    if (lo) return CODE_ZERO;
    return lv;
  endfunction : conv_code

  // pin synchronisers
  logic sel_s1_reg, sel_s2_reg, sel_d_reg;
  logic clk_s1_reg, clk_s2_reg, clk_d_reg;
  logic cmd_s1_reg, cmd_s2_reg;
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      sel_s1_reg <= 1'b1;
      sel_s2_reg <= 1'b1;
      sel_d_reg <= 1'b1;
      clk_s1_reg <= 1'b0;
      clk_s2_reg <= 1'b0;
      clk_d_reg <= 1'b0;
      cmd_s1_reg <= 1'b0;
      cmd_s2_reg <= 1'b0;
    end else begin
      sel_s1_reg <= link_in.select_n;
      sel_s2_reg <= sel_s1_reg;
      sel_d_reg <= sel_s2_reg;
      clk_s1_reg <= link_in.shift_clock;
      clk_s2_reg <= clk_s1_reg;
      clk_d_reg <= clk_s2_reg;
      cmd_s1_reg <= link_in.cmd;
      cmd_s2_reg <= cmd_s1_reg;
    end
  end

  logic sel_fall, sel_high, sclk_rise, sclk_fall;
  assign sel_fall = !sel_s2_reg && sel_d_reg;
  assign sel_high = sel_s2_reg;
  assign sclk_rise = clk_s2_reg && !clk_d_reg;
  assign sclk_fall = !clk_s2_reg && clk_d_reg;

  sac_lst_type lst_reg, lst_next;
  sac_cst_type cst_reg, cst_next;
  logic [CNT_W-1:0] rise_cnt_reg, rise_cnt_next, fall_cnt_reg, fall_cnt_next;
  logic [TMR_W-1:0] tmr_reg, tmr_next, conv_cnt_reg, conv_cnt_next;
  logic [CMD_W-1:0] cmd_reg, cmd_next;
  logic [ADDR_W-1:0] chan_reg, chan_next;
  logic [OUT_W-1:0] out_reg, out_next;
  logic oe_reg, oe_next, sample_reg, sample_next, done_reg, done_next;
  sac_result_type res_reg, res_next, conv_res;
  sac_fmt_type res_fmt_reg, res_fmt_next, conv_fmt_reg, conv_fmt_next;
  logic [ADDR_W-1:0] conv_chan_reg, conv_chan_next;
  logic [31:0] ctrl_reg, ctrl_next, rdata_reg, rdata_next;
  logic [ST_W-1:0] stat_reg, stat_next, mask_reg, mask_next, ev;
  logic slverr_reg, slverr_next;
  logic [CNT_W-1:0] fall_n;
  logic conv_go, setup_ph, access_ph, mapped;

  always_comb begin
    lst_next = lst_reg;
    cst_next = cst_reg;
    rise_cnt_next = rise_cnt_reg;
    fall_cnt_next = fall_cnt_reg;
    tmr_next = tmr_reg;
    conv_cnt_next = conv_cnt_reg;
    cmd_next = cmd_reg;
    chan_next = chan_reg;
    out_next = out_reg;
    oe_next = oe_reg;
    sample_next = sample_reg;
    done_next = done_reg;
    res_next = res_reg;
    res_fmt_next = res_fmt_reg;
    conv_fmt_next = conv_fmt_reg;
    conv_chan_next = conv_chan_reg;
    ev = '0;
    conv_go = 1'b0;
    fall_n = fall_cnt_reg + 5'h01;
    conv_res.channel = conv_chan_reg;
    conv_res.code = conv_code(conv_chan_reg, analog_level_in,
                              above_ref_in, below_ref_in);
    unique case (lst_reg)
      L_OFF: ;
      L_SETUP: begin
        if (tmr_reg == '0) lst_next = L_SHIFT;
        else tmr_next = tmr_reg - 16'h0001;
      end
      L_SHIFT: begin
        if (sclk_rise && rise_cnt_reg < LEN_16) begin
          rise_cnt_next = rise_cnt_reg + 5'h01;
          if (rise_cnt_reg < LEN_8)
            cmd_next = {cmd_reg[CMD_W-2:0], cmd_s2_reg};
          if (rise_cnt_reg == ADDR_LAST_RISE)
            chan_next = {cmd_reg[2:0], cmd_s2_reg};
        end
        if (sclk_fall) begin
          fall_cnt_next = fall_n;
          out_next = {out_reg[OUT_W-2:0], 1'b0};
          if (fall_n == SAMPLE_EDGE) sample_next = 1'b1;
          if (fall_n >= LEN_8 &&
              fall_n == len_of(cmd_reg[CMD_LEN_LSB+1:CMD_LEN_LSB])) begin
            sample_next = 1'b0;
            conv_go = 1'b1;
            lst_next = L_HOLD;
            ev[ST_XFER] = 1'b1;
          end
        end
      end
      L_HOLD: ;
    endcase
    if (sel_high) begin
      lst_next = L_OFF;
      oe_next = 1'b0;
      sample_next = 1'b0;
    end
    if (sel_fall && ctrl_reg[CTRL_EN_BIT]) begin
      lst_next = L_SETUP;
      tmr_next = TMR_W'(CS_SETUP_CYC);
      rise_cnt_next = '0;
      fall_cnt_next = '0;
      sample_next = 1'b0;
      oe_next = 1'b1;
      out_next = fmt_word(res_reg, res_fmt_reg);
    end
    unique case (cst_reg)
      C_IDLE: begin
        if (conv_go) begin
          done_next = 1'b0;
          cst_next = C_CONV;
          conv_cnt_next = '0;
          conv_chan_next = chan_reg;
          conv_fmt_next = sac_fmt_type'(cmd_reg[3:0]);
        end
      end
      C_CONV: begin
        conv_cnt_next = conv_cnt_reg + 16'h0001;
        if (sel_fall && conv_cnt_reg < TMR_W'(ABORT_CYC)) begin
          cst_next = C_IDLE;
          done_next = 1'b1;
          ev[ST_ABORT] = 1'b1;
        end else if (conv_cnt_reg == TMR_W'(CONV_CYC - 1)) begin
          res_next = conv_res;
          res_fmt_next = conv_fmt_reg;
          cst_next = C_IDLE;
          done_next = 1'b1;
          ev[ST_CONV] = 1'b1;
          if (lst_reg == L_HOLD && !sel_high && !sel_fall) begin
            out_next = fmt_word(conv_res, conv_fmt_reg);
            lst_next = L_SHIFT;
            rise_cnt_next = '0;
            fall_cnt_next = '0;
          end
        end
      end
    endcase
  end

  // apb register file
  always_comb begin
    setup_ph = psel_in && !penable_in;
    access_ph = psel_in && penable_in;
    mapped = paddr_in == REG_CTRL || paddr_in == REG_RESULT ||
             paddr_in == REG_STATUS || paddr_in == REG_MASK;
    ctrl_next = ctrl_reg;
    mask_next = mask_reg;
    rdata_next = rdata_reg;
    slverr_next = slverr_reg;
    stat_next = stat_reg;
    if (setup_ph) begin
      slverr_next = !mapped;
      unique case (paddr_in)
        REG_CTRL: rdata_next = ctrl_reg;
        REG_RESULT: begin
          rdata_next = '0;
          rdata_next[RES_W-1:0] = res_reg.code;
          rdata_next[RES_CHAN_LSB+ADDR_W-1:RES_CHAN_LSB] = res_reg.channel;
          rdata_next[RES_BUSY_BIT] = cst_reg == C_CONV;
        end
        REG_STATUS: rdata_next = {29'h0, stat_reg};
        REG_MASK: rdata_next = {29'h0, mask_reg};
        default: rdata_next = '0;
      endcase
    end
    if (access_ph && pwrite_in && paddr_in == REG_CTRL)
      ctrl_next = {31'h0, pwdata_in[CTRL_EN_BIT]};
    if (access_ph && pwrite_in && paddr_in == REG_MASK)
      mask_next = pwdata_in[ST_W-1:0];
    // clear only bits seen by the read; new events win
    if (access_ph && !pwrite_in && paddr_in == REG_STATUS)
      stat_next = stat_reg & ~rdata_reg[ST_W-1:0];
    stat_next = stat_next | ev;
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      lst_reg <= L_OFF;
      cst_reg <= C_IDLE;
      rise_cnt_reg <= '0;
      fall_cnt_reg <= '0;
      tmr_reg <= '0;
      conv_cnt_reg <= '0;
      cmd_reg <= '0;
      chan_reg <= '0;
      out_reg <= '0;
      oe_reg <= 1'b0;
      sample_reg <= 1'b0;
      done_reg <= 1'b1;
      res_reg <= '0;
      res_fmt_reg <= '0;
      conv_fmt_reg <= '0;
      conv_chan_reg <= '0;
      ctrl_reg <= CTRL_RST;
      mask_reg <= MASK_RST;
      stat_reg <= '0;
      rdata_reg <= '0;
      slverr_reg <= 1'b0;
    end else begin
      lst_reg <= lst_next;
      cst_reg <= cst_next;
      rise_cnt_reg <= rise_cnt_next;
      fall_cnt_reg <= fall_cnt_next;
      tmr_reg <= tmr_next;
      conv_cnt_reg <= conv_cnt_next;
      cmd_reg <= cmd_next;
      chan_reg <= chan_next;
      out_reg <= out_next;
      oe_reg <= oe_next;
      sample_reg <= sample_next;
      done_reg <= done_next;
      res_reg <= res_next;
      res_fmt_reg <= res_fmt_next;
      conv_fmt_reg <= conv_fmt_next;
      conv_chan_reg <= conv_chan_next;
      ctrl_reg <= ctrl_next;
      mask_reg <= mask_next;
      stat_reg <= stat_next;
      rdata_reg <= rdata_next;
      slverr_reg <= slverr_next;
    end
  end

  assign result_data_out = out_reg[OUT_W-1];
  assign result_oe_out = oe_reg;
  assign conv_done_out = done_reg;
  assign analog_channels_sel_out = chan_reg;
  assign sample_active_out = sample_reg;
  assign prdata_out = rdata_reg;
  assign pready_out = 1'b1;
  assign pslverr_out = slverr_reg;
  assign irq_out = |(stat_reg & mask_reg);
endmodule : sac_port

/* rtl/sac_pkg.sv */
package sac_pkg;
  // clock and timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int CS_SETUP_NS = 1000;
  localparam int CS_SETUP_CYC = (CS_SETUP_NS + CLK_PERIOD_NS - 1) /
                                CLK_PERIOD_NS;
  localparam int CONV_TIME_NS = 10000;
  localparam int CONV_CYC = CONV_TIME_NS / CLK_PERIOD_NS;
  localparam int ABORT_WINDOW_NS = 5000;
  localparam int ABORT_CYC = ABORT_WINDOW_NS / CLK_PERIOD_NS;
  // widths
  localparam int RES_W = 12;
  localparam int CMD_W = 8;
  localparam int ADDR_W = 4;
  localparam int OUT_W = 16;
  localparam int CNT_W = 5;
  localparam int TMR_W = 16;
  localparam int ST_W = 3;
  // transfer framing
  localparam logic [CNT_W-1:0] SAMPLE_EDGE = 5'h04;
  localparam logic [CNT_W-1:0] ADDR_LAST_RISE = 5'h03;
  localparam logic [CNT_W-1:0] LEN_8 = 5'h08;
  localparam logic [CNT_W-1:0] LEN_12 = 5'h0c;
  localparam logic [CNT_W-1:0] LEN_16 = 5'h10;
  localparam logic [1:0] LEN_CODE_8 = 2'h1;
  localparam logic [1:0] LEN_CODE_16 = 2'h3;
  // command field positions
  localparam int CMD_LEN_LSB = 2;
  localparam int CMD_LSBF_BIT = 1;
  localparam int CMD_BIP_BIT = 0;
  // self-test addresses and codes
  localparam logic [ADDR_W-1:0] ADDR_TEST_MID = 4'hb;
  localparam logic [ADDR_W-1:0] ADDR_TEST_ZERO = 4'hc;
  localparam logic [ADDR_W-1:0] ADDR_TEST_FULL = 4'hd;
  localparam logic [RES_W-1:0] CODE_MID = 12'h800;
  localparam logic [RES_W-1:0] CODE_ZERO = 12'h000;
  localparam logic [RES_W-1:0] CODE_FULL = 12'hfff;
  // register map
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_RESULT = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_MASK = 8'h0c;
  localparam logic [31:0] CTRL_RST = 32'h00000001;
  localparam logic [ST_W-1:0] MASK_RST = 3'h0;
  localparam int CTRL_EN_BIT = 0;
  localparam int ST_CONV = 0;
  localparam int ST_XFER = 1;
  localparam int ST_ABORT = 2;
  localparam int RES_CHAN_LSB = 12;
  localparam int RES_BUSY_BIT = 16;

  typedef struct packed {
    logic select_n;
    logic shift_clock;
    logic cmd;
  } sac_link_in_type;

  typedef struct packed {
    logic [1:0] len;
    logic lsb_first;
    logic bipolar;
  } sac_fmt_type;

  typedef struct packed {
    logic [ADDR_W-1:0] channel;
    logic [RES_W-1:0] code;
  } sac_result_type;
endpackage : sac_pkg

/* verif/sac_port_chk.sv */
`timescale 1ns/1ps
module sac_port_chk
  import sac_pkg::*;
(
  // watched ports
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic [7:0] paddr_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic [31:0] prdata_out,
  input wire logic pready_out,
  input wire logic pslverr_out,
  input wire sac_link_in_type link_in,
  input wire logic result_oe_out,
  input wire logic conv_done_out,
  input wire logic sample_active_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  a_oe_idle: assert property (link_in.select_n [*6] |-> !result_oe_out)
    else $error("result pin driven while idle");
  a_oe_sel: assert property (!link_in.select_n [*6] |-> result_oe_out)
    else $error("result pin not driven");
  a_sample_idle: assert property (
    link_in.select_n [*6] |-> !sample_active_out)
    else $error("sampling while idle");
  a_done_hold: assert property (
    $fell(conv_done_out) |-> !conv_done_out [*5])
    else $error("done rose too early");
  a_done_bound: assert property (
    $fell(conv_done_out) |-> ##[1:220] conv_done_out)
    else $error("conversion never ended");
  a_handover: assert property (
    $fell(conv_done_out) |-> $past(sample_active_out, 2))
    else $error("done fell without sampling end");
  a_ready_now: assert property (psel_in && penable_in |-> pready_out)
    else $error("wait state inserted");
  a_err_unmapped: assert property (
    psel_in && penable_in && paddr_in > 8'h0c |-> pslverr_out)
    else $error("unmapped access not refused");
  a_err_zero: assert property (pslverr_out |-> prdata_out == 32'h0)
    else $error("refused read returned data");
  c_conv: cover property ($rose(conv_done_out));
  c_oe: cover property ($rose(result_oe_out));
  c_err: cover property (pslverr_out);
  c_held: cover property (!link_in.select_n && $rose(conv_done_out));
endmodule : sac_port_chk

bind sac_port sac_port_chk i_chk (.clk_in, .resetn_in, .paddr_in, .psel_in,
  .penable_in, .prdata_out, .pready_out, .pslverr_out, .link_in,
  .result_oe_out, .conv_done_out, .sample_active_out);

/* verif/sac_host.sv */
`timescale 1ns/1ps
module sac_host
  import sac_pkg::*;
(
  // clock
  input wire logic clk_in,
  // serial link
  input wire logic data_in,
  output sac_link_in_type link_out
);
  initial link_out = 3'b100;
  task automatic xfer(input logic [7:0] cmd, input int n, input int hold,
                      output logic [15:0] rd);
    rd = 16'h0;
    @(posedge clk_in);
    link_out.select_n <= 1'b0;
    repeat (30) @(posedge clk_in);
    for (int i = 0; i < n; i++) begin
      link_out.cmd <= (i < 8) ? cmd[7-i] : ~link_out.cmd;
      @(posedge clk_in);
      link_out.shift_clock <= 1'b1;
      repeat (4) @(posedge clk_in);
      rd = {rd[14:0], data_in};
      link_out.shift_clock <= 1'b0;
      repeat (3) @(posedge clk_in);
    end
    // stay selected through the conversion, take new first bit
    if (hold > 0) begin
      repeat (hold) @(posedge clk_in);
      rd = {rd[14:0], data_in};
    end
    link_out.select_n <= 1'b1;
    link_out.cmd <= ~link_out.cmd;
    repeat (4) @(posedge clk_in);
  endtask : xfer
endmodule : sac_host

/* verif/testbench.sv */
`timescale 1ns/1ps
module testbench
  import sac_pkg::*;
;
  logic clk_in, resetn_in, psel_in, penable_in, pwrite_in;
  logic [7:0] paddr_in;
  logic [31:0] pwdata_in, prdata_out;
  logic pready_out, pslverr_out, result_data_out, result_oe_out;
  logic conv_done_out, above_ref_in, below_ref_in, sample_active_out, irq_out;
  logic [RES_W-1:0] analog_level_in;
  logic [ADDR_W-1:0] analog_channels_sel_out;
  sac_link_in_type link_in;
  logic pin_last = 1'b0;
  int fails = 0;
  int check_count = 0;
  int cyc = 0;
  logic [7:0] cmd_t [10] = '{8'hb0, 8'hc0, 8'hd0, 8'h10, 8'h20, 8'h30,
                             8'h32, 8'h4d, 8'h54, 8'h60};
  logic [11:0] lvl_t [10] = '{12'h0, 12'h0, 12'h0, 12'h123, 12'h456,
                              12'h5a3, 12'h5a3, 12'h0f0, 12'habc, 12'h3c5};
  logic [1:0] rng_t [10] = '{2'h0, 2'h2, 2'h1, 2'h2, 2'h1, 2'h0, 2'h0,
                             2'h0, 2'h0, 2'h0};
  // released pin shows the inverse of its last level
  wire logic result_pin = result_oe_out ? result_data_out : ~pin_last;
  sac_port i_dut (.clk_in, .resetn_in, .paddr_in, .psel_in, .penable_in,
    .pwrite_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .link_in,
    .result_data_out, .result_oe_out, .conv_done_out, .analog_level_in,
    .above_ref_in, .below_ref_in, .analog_channels_sel_out,
    .sample_active_out, .irq_out);
  sac_host i_host (.clk_in, .data_in(result_pin), .link_out(link_in));
  initial begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    if (result_oe_out) pin_last <= result_data_out;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      tally_and_finish();
    end
  end
  function automatic int len(input logic [3:0] f);
    return (f[3:2] == 2'h1) ? 8 : (f[3:2] == 2'h3) ? 16 : 12;
  endfunction : len
  function automatic logic [15:0] fmt(input logic [11:0] c,
                                      input logic [3:0] f, input int n);
    logic [11:0] w;
    w = f[0] ? c ^ 12'h800 : c;
    if (f[1]) w = {<<{w}};
    return (n == 8) ? {8'h0, w[11:4]} : (n == 16) ? {w, 4'h0} : {4'h0, w};
  endfunction : fmt
  function automatic logic [11:0] code(input logic [3:0] a,
                                       input logic [11:0] l,
                                       input logic [1:0] r);
    if (a == ADDR_TEST_MID) return CODE_MID;
    if (a == ADDR_TEST_ZERO) return CODE_ZERO;
    if (a == ADDR_TEST_FULL) return CODE_FULL;
    return r[1] ? 12'hfff : r[0] ? 12'h000 : l;
  endfunction : code
  task automatic cmp(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q,
                     output logic e);
    @(posedge clk_in);
    psel_in <= 1'b1;
    penable_in <= 1'b0;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge clk_in);
    penable_in <= 1'b1;
    do @(posedge clk_in); while (pready_out !== 1'b1);
    q = prdata_out;
    e = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask : apb
  task automatic apb_chk(input logic [7:0] a, input logic [31:0] x,
                         input logic er);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    cmp("read data", x, q);
    cmp("slave error", {31'h0, er}, {31'h0, e});
  endtask : apb_chk
  task automatic apb_w(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask : apb_w
  task automatic wait_done();
    int k;
    for (k = 0; k < 400 && conv_done_out !== 1'b1; k++) @(negedge clk_in);
    cmp("done", 32'h1, {31'h0, conv_done_out});
  endtask : wait_done
  task automatic t_regs();
    apb_chk(REG_CTRL, CTRL_RST, 1'b0);
    apb_chk(REG_MASK, 32'h0, 1'b0);
    apb_chk(8'h10, 32'h0, 1'b1);
    apb_w(REG_MASK, 32'h1);
    apb_chk(REG_MASK, 32'h1, 1'b0);
    apb_w(REG_CTRL, 32'h0);
    apb_chk(REG_CTRL, 32'h0, 1'b0);
    apb_w(REG_CTRL, CTRL_RST);
    $display("test regs done");
  endtask : t_regs
  task automatic t_stream();
    logic [15:0] rd;
    logic [11:0] pc;
    logic [3:0] pf;
    pc = 12'h0;
    pf = 4'h0;
    for (int i = 0; i < 10; i++) begin
      analog_level_in <= lvl_t[i];
      {above_ref_in, below_ref_in} <= rng_t[i];
      i_host.xfer(cmd_t[i], len(cmd_t[i][3:0]), 0, rd);
      @(negedge clk_in);
      if (i > 0)
        cmp("serial", fmt(pc, pf, len(cmd_t[i][3:0])), rd);
      cmp("done low", 32'h0, {31'h0, conv_done_out});
      cmp("channel", cmd_t[i][7:4], analog_channels_sel_out);
      wait_done();
      cmp("irq", 32'h1, {31'h0, irq_out});
      pc = code(cmd_t[i][7:4], lvl_t[i], rng_t[i]);
      pf = cmd_t[i][3:0];
      apb_chk(REG_RESULT, {16'h0, cmd_t[i][7:4], pc}, 1'b0);
      apb_chk(REG_STATUS, 32'h3, 1'b0);
    end
    $display("test stream done");
  endtask : t_stream
  task automatic t_abort();
    logic [15:0] rd;
    analog_level_in <= 12'h111;
    i_host.xfer(8'h60, 12, 0, rd);
    cmp("serial first", 32'h3c5, rd);
    analog_level_in <= 12'h222;
    i_host.xfer(8'h70, 12, 0, rd);
    cmp("serial aborted", 32'h3c5, rd);
    wait_done();
    apb_w(REG_MASK, 32'h0);
    @(negedge clk_in);
    cmp("irq masked", 32'h0, {31'h0, irq_out});
    apb_w(REG_MASK, 32'h4);
    @(negedge clk_in);
    cmp("irq abort", 32'h1, {31'h0, irq_out});
    apb_chk(REG_RESULT, 32'h7222, 1'b0);
    apb_chk(REG_STATUS, 32'h7, 1'b0);
    @(negedge clk_in);
    cmp("irq cleared", 32'h0, {31'h0, irq_out});
    $display("test abort done");
  endtask : t_abort
  task automatic t_hold();
    logic [15:0] rd;
    // old 12 bits, then the first bit of the full-scale self-test result
    i_host.xfer(8'hd0, 12, 220, rd);
    cmp("serial held", 32'h445, rd);
    cmp("done held", 32'h1, {31'h0, conv_done_out});
    apb_chk(REG_RESULT, 32'hdfff, 1'b0);
    apb_chk(REG_STATUS, 32'h3, 1'b0);
    $display("test hold done");
  endtask : t_hold
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : tally_and_finish
  initial begin
    resetn_in = 1'b0;
    {psel_in, penable_in, pwrite_in, paddr_in, pwdata_in} = '0;
    {analog_level_in, above_ref_in, below_ref_in} = '0;
    repeat (10) @(posedge clk_in);
    resetn_in <= 1'b1;
    t_regs();
    t_stream();
    t_abort();
    t_hold();
    tally_and_finish();
  end
endmodule : testbench
